//--- bench/tb_top.sv
// self-checking bench for the fixed-range memory type lookup
// assumes range_type_pkg, the design files and var_range_model compile first
`timescale 1ns/100ps
module tb_top;
  localparam int AddrW = 52;  // physical address width
  localparam logic [2:0] CodeTab [5] = '{3'h0, 3'h1, 3'h4, 3'h5, 3'h6};  // defined codes
  // clock, reset and pins
  logic             sys_clk;
  logic             reset_n;
  logic             msrReq, msrWrite, msrAck, msrFault;
  logic [3:0]       msrIndex;
  logic [63:0]      msrWdata, msrRdata;
  logic             varHit, lookupValid, lookupDone, fixedHit;
  logic [7:0]       varType, rangeType;
  logic [AddrW-1:0] lookupAddr;
  logic [2:0]       memType;
  logic             readToMemory, writeToMemory, cacheable, wcAllowed, specAllowed;
  logic             readAlloc, writeAlloc, writeThrough, hitInvalidate, allocModified;
  logic             typeUndefined, globalEnabled, fixedEnabled, extEnabled, hitEn;
  logic [AddrW-21:0] hitMeg;
  int               nFail, cmpCount, cycles;
  // device under test
  fixed_range_type_lookup #(.AddrW(AddrW)) dut_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .msrReq(msrReq), .msrWrite(msrWrite),
    .msrIndex(msrIndex), .msrWdata(msrWdata), .msrAck(msrAck), .msrFault(msrFault),
    .msrRdata(msrRdata), .varHit(varHit), .varType(varType), .lookupValid(lookupValid),
    .lookupAddr(lookupAddr), .lookupDone(lookupDone), .memType(memType),
    .fixedHit(fixedHit), .readToMemory(readToMemory), .writeToMemory(writeToMemory),
    .cacheable(cacheable), .wcAllowed(wcAllowed), .specAllowed(specAllowed),
    .readAlloc(readAlloc), .writeAlloc(writeAlloc), .writeThrough(writeThrough),
    .hitInvalidate(hitInvalidate), .allocModified(allocModified),
    .typeUndefined(typeUndefined), .globalEnabled(globalEnabled),
    .fixedEnabled(fixedEnabled), .extEnabled(extEnabled));
  // variable-range source
  var_range_model #(.AddrW(AddrW)) pipe_u (
    .lookupAddr(lookupAddr), .hitEn(hitEn), .hitMeg(hitMeg), .rangeType(rangeType),
    .varHit(varHit), .varType(varType));
  // clock of 10 ns
  always #5 sys_clk = ~sys_clk;
  // prints the counts and the verdict, then ends the run
  task automatic giveVerdict();
    $display("comparisons %0d, mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles >= 4000) begin
      nFail++;
      $display("wrong value at %0t: run did not finish", $time);
      giveVerdict();
    end
  end
  // one comparison
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // permissions expected of a type code
  function automatic range_type_pkg::attr_t expAttr(input logic [2:0] c);
    case (c)
      3'h0: return 9'h000;
      3'h1: return 9'h0C0;
      3'h4: return 9'h128;
      3'h5: return 9'h12C;
      3'h6: return 9'h132;
      default: return 9'h001;
    endcase
  endfunction
  // one register access, answer checked the cycle after
  task automatic acc(input logic wr, input logic [3:0] idx, input logic [63:0] wd,
                     input logic [63:0] expRd, input logic expFlt);
    @(posedge sys_clk);
    #1;
    msrReq   = 1'b1;
    msrWrite = wr;
    msrIndex = idx;
    msrWdata = wd;
    @(posedge sys_clk);
    #1;
    msrReq   = 1'b0;
    msrWdata = ~wd;
    chk(64'({msrAck, msrFault}), 64'({1'b1, expFlt}), "register answer");
    if (!wr) begin
      chk(msrRdata, expRd, "register read");
    end
  endtask
  // one lookup; hrw is fixed hit, read and write memory bits
  task automatic lk(input logic [AddrW-1:0] a, input logic [2:0] c, input logic [2:0] hrw);
    @(posedge sys_clk);
    #1;
    lookupValid = 1'b1;
    lookupAddr  = a;
    @(posedge sys_clk);
    #1;
    lookupValid = 1'b0;
    lookupAddr  = ~a;
    chk(64'(lookupDone), 64'h1, "lookup answer");
    chk(64'({memType, fixedHit, readToMemory, writeToMemory, cacheable, wcAllowed,
             specAllowed, readAlloc, writeAlloc, writeThrough, hitInvalidate,
             allocModified, typeUndefined}), 64'({c, hrw, expAttr(c)}), "lookup result");
  endtask
  // reset contents of every register
  task automatic tReset();
    chk(64'({globalEnabled, fixedEnabled, extEnabled, msrAck, lookupDone}), 64'h0, "reset");
    for (int i = 0; i < 13; i++) begin
      acc(1'b0, 4'(i), 64'h0, 64'h0, 1'b0);
    end
  endtask
  // full-width registers, kept bits, unmapped indices
  task automatic tRegs();
    acc(1'b1, 4'h3, 64'hFEDC_BA98_7654_3210, 64'h0, 1'b0);
    acc(1'b1, 4'hB, '1, 64'h0, 1'b0);
    acc(1'b0, 4'hB, 64'h0, 64'h0000_0000_0000_0CFF, 1'b0);
    chk(64'({globalEnabled, fixedEnabled}), 64'h3, "enables");
    acc(1'b1, 4'hC, '1, 64'h0, 1'b0);
    chk(64'(extEnabled), 64'h1, "extended enable");
    acc(1'b0, 4'hC, 64'h0, 64'h1, 1'b0);
    for (int i = 13; i < 16; i++) begin
      acc(1'b1, 4'(i), '1, 64'h0, 1'b1);
      acc(1'b0, 4'(i), 64'h0, 64'h0, 1'b1);
    end
    acc(1'b0, 4'h3, 64'h0, 64'hFEDC_BA98_7654_3210, 1'b0);
    acc(1'b1, 4'hC, 64'h0, 64'h0, 1'b0);
    acc(1'b1, 4'h3, 64'h0, 64'h0, 1'b0);
  endtask
  // mechanism off forces uncacheable everywhere
  task automatic tDisabled();
    acc(1'b1, 4'h0, 64'h0606_0606_0606_0606, 64'h0, 1'b0);
    acc(1'b0, 4'h0, 64'h0, 64'h0606_0606_0606_0606, 1'b0);
    acc(1'b1, 4'hB, 64'h406, 64'h0, 1'b0);
    hitEn  = 1'b1;
    hitMeg = 32'(1);
    rangeType = 8'h06;
    lk(52'h0, 3'h0, 3'h0);
    lk(52'h10_0000, 3'h0, 3'h0);
  endtask
  // every code through default and fixed-off paths, code 1 through variable
  task automatic tTypes();
    hitEn = 1'b0;
    for (int c = 0; c < 8; c++) begin
      acc(1'b1, 4'hB, 64'h800 | 64'(c), 64'h0, 1'b0);
      lk(52'h10_0000, 3'(c), 3'h0);
      lk(52'h0, 3'(c), 3'h0);
    end
    hitEn     = 1'b1;
    hitMeg    = '0;
    rangeType = 8'h01;
    lk(52'h0, 3'h1, 3'h0);
    hitMeg = 32'(2);
    lk(52'h20_0000, 3'h1, 3'h0);
  endtask
  // each of the 88 sub-ranges at its first and last byte
  task automatic tMap();
    logic [63:0] d;
    logic [19:0] base, size;
    hitMeg    = '0;
    rangeType = 8'h02;
    acc(1'b1, 4'hB, 64'hC07, 64'h0, 1'b0);
    for (int r = 0; r < 11; r++) begin
      d = '0;
      for (int b = 0; b < 8; b++) begin
        d[8*b +: 8] = {5'h00, CodeTab[(r + b) % 5]};
      end
      acc(1'b1, 4'(r), d, 64'h0, 1'b0);
    end
    for (int r = 0; r < 11; r++) begin
      for (int b = 0; b < 8; b++) begin
        size = (r == 0) ? 20'h10000 : (r < 3) ? 20'h04000 : 20'h01000;
        base = (r == 0) ? 20'h00000 : (r < 3) ? 20'h80000 + 20'(r - 1) * 20'h20000 :
               20'hC0000 + 20'(r - 3) * 20'h08000;
        base = base + 20'(b) * size;
        lk(52'(base), CodeTab[(r + b) % 5], 3'h4);
        lk(52'(base + size - 20'h1), CodeTab[(r + b) % 5], 3'h4);
      end
    end
    lk(52'h10_0000, 3'h7, 3'h0);
  endtask
  // extended bits only from fixed fields and only when enabled
  task automatic tExt();
    hitMeg    = 32'(1);
    rangeType = 8'h1E;
    acc(1'b1, 4'h0, 64'h09FE, 64'h0, 1'b0);
    acc(1'b1, 4'hB, 64'hC1C, 64'h0, 1'b0);
    lk(52'h0, 3'h6, 3'h4);
    acc(1'b1, 4'hC, 64'h1, 64'h0, 1'b0);
    lk(52'h0, 3'h6, 3'h7);
    lk(52'h1_0000, 3'h1, 3'h5);
    lk(52'h10_0000, 3'h6, 3'h0);
    hitEn = 1'b0;
    lk(52'h10_0000, 3'h4, 3'h0);
  endtask
  // main sequence
  initial begin
    sys_clk     = 1'b0;
    reset_n     = 1'b0;
    msrReq      = 1'b0;
    msrWrite    = 1'b0;
    msrIndex    = 4'h0;
    msrWdata    = '0;
    lookupValid = 1'b0;
    lookupAddr  = '0;
    hitEn       = 1'b0;
    hitMeg      = '0;
    rangeType   = 8'h00;
    nFail       = 0;
    cmpCount    = 0;
    cycles      = 0;
    repeat (5) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    tReset();
    tRegs();
    tDisabled();
    tTypes();
    tMap();
    tExt();
    giveVerdict();
  end
endmodule

//--- bench/var_range_model.sv
// variable-range answer source standing beside the lookup block
// assumes the bench sets the range and the block samples it at its own edge
`timescale 1ns/100ps
module var_range_model #(
  parameter int AddrW = 52  // physical address width
) (
  // address presented to the lookup
  lookupAddr,
  // range settings from the bench
  hitEn,
  hitMeg,
  rangeType,
  // variable-range answer
  varHit,
  varType
);
  input  wire logic [AddrW-1:0]  lookupAddr;  // address under lookup
  input  wire logic              hitEn;       // range in use
  input  wire logic [AddrW-21:0] hitMeg;      // megabyte that the range covers
  input  wire logic [7:0]        rangeType;   // type byte of the range
  output logic                   varHit;      // address falls in the range
  output logic [7:0]             varType;     // type byte while hit
  // one range of one megabyte, anywhere in the address space
  always_comb begin
    varHit = hitEn && (lookupAddr[AddrW-1:20] == hitMeg);
    // a miss shows the inverse, never a stale type
    varType = varHit ? rangeType : ~rangeType;
  end
endmodule

//--- verilog/fixed_range_type_lookup.sv
// fixed-range memory type registers and address lookup
// assumes msr requests and lookups from the same core clock
//
// Functional notes
// - memory type is type field bits 2:0
// - extended: 7:5 reserved, 4:3 memory bits
// - extended bits only for fixed ranges
// - standard decode unless extended explicitly enabled
// - type 0 uncacheable, nothing allowed
// - type 1 write-combining, speculative reads allowed
// - type 4 writethrough, no write allocate
// - type 5 write-protect, write hit invalidates
// - type 6 writeback, write allocates modified
// - disabled mechanism gives uncacheable
// - cache only where a register allows
// - fixed ranges cover lowest megabyte only
// - uncovered address gets software default type
// - registers 64 bits, msr read/write
// - eight byte-wide type fields per register
// - first 512k in eight 64k ranges
// - next 256k in sixteen 16k ranges
// - top 256k in sixty-four 4k ranges
// - low byte types lowest sub-range
// - extended encoding allows I/O range use
// - global enable on all; off forces uncacheable
// - fixed enable gates fixed ranges only
`timescale 1ns/100ps
module fixed_range_type_lookup #(
  parameter int AddrW = 52  // physical address width
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // msr access port
  input  wire logic             msrReq,
  input  wire logic             msrWrite,
  input  wire logic [3:0]       msrIndex,
  input  wire logic [63:0]      msrWdata,
  output logic                  msrAck,
  output logic                  msrFault,
  output logic [63:0]           msrRdata,
  // variable-range result from outside
  input  wire logic             varHit,
  input  wire logic [7:0]       varType,
  // lookup request
  input  wire logic             lookupValid,
  input  wire logic [AddrW-1:0] lookupAddr,
  // lookup answer
  output logic                  lookupDone,
  output logic [2:0]            memType,
  output logic                  fixedHit,
  output logic                  readToMemory,
  output logic                  writeToMemory,
  output logic                  cacheable,
  output logic                  wcAllowed,
  output logic                  specAllowed,
  output logic                  readAlloc,
  output logic                  writeAlloc,
  output logic                  writeThrough,
  output logic                  hitInvalidate,
  output logic                  allocModified,
  output logic                  typeUndefined,
  // enable status
  output logic                  globalEnabled,
  output logic                  fixedEnabled,
  output logic                  extEnabled
);
  localparam int NF = range_type_pkg::NumFixed;

  // whole module state
  typedef struct packed {
    logic [NF-1:0][63:0]   fix;       // fixed-range registers
    logic [7:0]            defType;   // default type field
    logic                  fixEn;     // fixed_range_enable
    logic                  globEn;    // global enable
    logic                  extEn;     // extended encoding enable
    logic                  ack;       // msr answer strobe
    logic                  fault;     // msr index unmapped
    logic [63:0]           rdata;     // msr read data
    logic                  done;      // lookup answer strobe
    logic [2:0]            mType;     // resolved type
    logic                  fHit;      // fixed register used
    logic                  read_to_memory_bit;     // extended read bit
    logic                  write_to_memory_bit;     // extended write bit
    range_type_pkg::attr_t attr;      // decoded permissions
  } state_t;

  state_t q;  // registered state
  state_t d;  // next state

  // decoder link
  type_attr_if tif ();

  type_attr_decoder u_decoder (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tif     (tif.decoder)
  );

  // lookup helpers
  logic [19:0]        lowAddr;    // offset inside first megabyte
  logic               belowMeg;   // address is under one megabyte
  logic [3:0]         regSel;     // selected fixed register
  logic [2:0]         byteSel;    // selected byte lane
  logic [7:0]         fixField;   // selected type field
  logic [2:0]         effType;    // type fed to decoder
  logic               effRd;      // extended read bit in effect
  logic               effWr;      // extended write bit in effect
  logic               useFix;     // fixed field chosen
  logic [63:0]        defWord;    // default register read image

  // address split into register and byte lane
  always_comb begin
    lowAddr  = lookupAddr[range_type_pkg::LowMegBits-1:0];
    // upper bits zero means inside the fixed window
    belowMeg = (lookupAddr[AddrW-1:range_type_pkg::LowMegBits] == '0);
    if (lowAddr < range_type_pkg::End64k) begin
      // one register, 64k per byte
      regSel  = range_type_pkg::IdxFix64k;
      byteSel = lowAddr[range_type_pkg::Sel64kLsb +: 3];
    end else if (lowAddr < range_type_pkg::End16k) begin
      // two registers, 16k per byte
      regSel  = range_type_pkg::IdxFix16k
              + {3'h0, lowAddr[range_type_pkg::Blk16kBit]};
      byteSel = lowAddr[range_type_pkg::Sel16kLsb +: 3];
    end else begin
      // eight registers, 4k per byte
      regSel  = range_type_pkg::IdxFix4k
              + {1'b0, lowAddr[range_type_pkg::Blk4kLsb +: 3]};
      byteSel = lowAddr[range_type_pkg::Sel4kLsb +: 3];
    end
  end

  // pick field: lowest byte types lowest sub-range
  always_comb begin
    fixField = q.fix[regSel][byteSel*range_type_pkg::FieldW +: range_type_pkg::FieldW];
  end

  // type selection priority
  always_comb begin
    useFix  = 1'b0;
    effRd   = 1'b0;
    effWr   = 1'b0;
    if (!q.globEn) begin
      // mechanism off: uncacheable whatever the default
      effType = range_type_pkg::TypeUc;
    end else if (belowMeg && q.fixEn) begin
      // fixed ranges win under one megabyte
      useFix  = 1'b1;
      effType = fixField[range_type_pkg::TypeW-1:0];
      if (q.extEn) begin
        // extended bits only when explicitly enabled
        effRd = fixField[range_type_pkg::RdMemBit];
        effWr = fixField[range_type_pkg::WrMemBit];
      end
    end else if (varHit) begin
      // variable ranges keep the standard decode
      effType = varType[range_type_pkg::TypeW-1:0];
    end else begin
      // nothing covers it: software default
      effType = q.defType[range_type_pkg::TypeW-1:0];
    end
  end

  // hand type to decoder
  assign tif.memType = effType;

  // read image of default register, reserved bits zero
  always_comb begin
    defWord = '0;
    defWord[range_type_pkg::FieldW-1:0] = q.defType;
    defWord[range_type_pkg::FeBit] = q.fixEn;
    defWord[range_type_pkg::EnBit] = q.globEn;
  end

  // next-state logic
  always_comb begin
    d       = q;
    d.ack   = 1'b0;
    d.fault = 1'b0;
    // msr access, answered next cycle
    if (msrReq) begin
      d.ack = 1'b1;
      if (msrIndex < 4'(NF)) begin
        // fixed-range registers, full 64 bits
        if (msrWrite) begin
          d.fix[msrIndex] = msrWdata;
        end else begin
          d.rdata = q.fix[msrIndex];
        end
      end else if (msrIndex == range_type_pkg::IdxDefType) begin
        // default type and enables
        if (msrWrite) begin
          d.defType = msrWdata[range_type_pkg::FieldW-1:0];
          d.fixEn   = msrWdata[range_type_pkg::FeBit];
          d.globEn  = msrWdata[range_type_pkg::EnBit];
        end else begin
          d.rdata = defWord;
        end
      end else if (msrIndex == range_type_pkg::IdxExtCtl) begin
        // extended encoding switch
        if (msrWrite) begin
          d.extEn = msrWdata[range_type_pkg::ExtEnBit];
        end else begin
          d.rdata = 64'({q.extEn});
        end
      end else begin
        // unmapped index: fault, reads zero
        d.fault = 1'b1;
        if (!msrWrite) begin
          d.rdata = '0;
        end
      end
    end
    // lookup answer, one cycle after request
    d.done = lookupValid;
    if (lookupValid) begin
      d.mType = effType;
      d.fHit  = useFix;
      d.read_to_memory_bit = effRd;
      d.write_to_memory_bit = effWr;
      d.attr  = tif.attr;
    end
  end

  // state register, synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      q         <= '0;
      q.fix     <= {NF{range_type_pkg::FixReset}};
      q.defType <= range_type_pkg::DefTypeReset;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state
  assign msrAck        = q.ack;
  assign msrFault      = q.fault;
  assign msrRdata      = q.rdata;
  assign lookupDone    = q.done;
  assign memType       = q.mType;
  assign fixedHit      = q.fHit;
  assign readToMemory  = q.read_to_memory_bit;
  assign writeToMemory = q.write_to_memory_bit;
  assign cacheable     = q.attr.cacheable;
  assign wcAllowed     = q.attr.wcAllowed;
  assign specAllowed   = q.attr.specAllowed;
  assign readAlloc     = q.attr.readAlloc;
  assign writeAlloc    = q.attr.writeAlloc;
  assign writeThrough  = q.attr.writeThrough;
  assign hitInvalidate = q.attr.hitInvalidate;
  assign allocModified = q.attr.allocModified;
  assign typeUndefined = q.attr.undefinedType;
  assign globalEnabled = q.globEn;
  assign fixedEnabled  = q.fixEn;
  assign extEnabled    = q.extEn;

  // checks

  // disabled mechanism answers uncacheable
  a_disabled_gives_uc: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid && !q.globEn
      |=> lookupDone && memType == range_type_pkg::TypeUc && !cacheable)
    else $error("disabled lookup not uncacheable");

  // answer exactly one cycle after request
  a_lookup_latency: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid |=> lookupDone ##1 (lookupDone == $past(lookupValid)))
    else $error("lookup answer timing wrong");

  // msr request answered next cycle
  a_msr_ack_next: assert property (@(posedge sys_clk) disable iff (!reset_n)
    msrReq |=> msrAck && (msrFault == ($past(msrIndex) > range_type_pkg::IdxExtCtl)))
    else $error("msr answer missing or fault wrong");

  // write, idle cycle, then read of a fixed register returns it
  a_msr_readback: assert property (@(posedge sys_clk) disable iff (!reset_n)
    msrReq && msrWrite && msrIndex == range_type_pkg::IdxFix64k
      ##1 !msrReq
      ##1 msrReq && !msrWrite && msrIndex == range_type_pkg::IdxFix64k
      |=> msrRdata == $past(msrWdata, 3))
    else $error("fixed register readback wrong");

  // address zero uses low byte of first register
  a_low_byte_first: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid && lookupAddr == '0 && q.globEn && q.fixEn
      |=> fixedHit && memType == $past(q.fix[0][2:0]))
    else $error("address zero did not use lowest field");

  // above one megabyte never uses a fixed field
  a_fixed_low_meg: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid && !belowMeg |=> !fixedHit)
    else $error("fixed range used above one megabyte");

  // fixed enable off with no variable hit falls to default
  a_fe_off_default: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid && q.globEn && !q.fixEn && !varHit
      |=> !fixedHit && memType == $past(q.defType[2:0]))
    else $error("default type not applied");

  // extended bits appear only on fixed hits with ext on
  a_ext_bits_gated: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid ##1 (readToMemory || writeToMemory) |-> fixedHit && $past(q.extEn))
    else $error("extended bits outside fixed ext mode");

  // write-protect invalidates on write hit
  a_wp_invalidates: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupDone && memType == range_type_pkg::TypeWp
      |-> hitInvalidate && readAlloc && !writeAlloc)
    else $error("write-protect attributes wrong");

  // writethrough never allocates on write miss
  a_wt_no_walloc: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupDone && memType == range_type_pkg::TypeWt
      |-> writeThrough && !writeAlloc && cacheable)
    else $error("writethrough attributes wrong");

  // cacheable answers only from a cacheable type with ranges on
  a_cache_only_typed: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid ##1 cacheable
      |-> $past(q.globEn) && (memType == range_type_pkg::TypeWt
        || memType == range_type_pkg::TypeWp || memType == range_type_pkg::TypeWb))
    else $error("cacheable answer without cacheable type");

  // extended bits stay low until explicitly enabled
  a_ext_off_no_bits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid && !q.extEn |=> !readToMemory && !writeToMemory)
    else $error("extended bits reported while disabled");

  // variable ranges use the standard decode only
  a_var_std_decode: assert property (@(posedge sys_clk) disable iff (!reset_n)
    lookupValid && q.globEn && !(belowMeg && q.fixEn) && varHit
      |=> memType == $past(varType[range_type_pkg::TypeW-1:0]) && !fixedHit
        && !readToMemory && !writeToMemory)
    else $error("variable range type decoded wrong");

  // unmapped index leaves every register untouched
  a_fault_no_write: assert property (@(posedge sys_clk) disable iff (!reset_n)
    msrReq && msrWrite && msrIndex > range_type_pkg::IdxExtCtl
      |=> $stable(q.fix) && $stable(q.defType) && $stable({q.globEn, q.fixEn, q.extEn}))
    else $error("unmapped write changed a register");

  // read data holds between read answers
  a_rdata_holds: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !(msrReq && !msrWrite) |=> $stable(msrRdata))
    else $error("read data changed without a read");

endmodule

//--- verilog/range_type_pkg.sv
// constants and types for the fixed-range memory type lookup
// assumes nothing beyond a SystemVerilog compiler
package range_type_pkg;
  // register file shape
  localparam int NumFixed = 11;              // 1x64k, 2x16k, 8x4k
  localparam int IdxW = 4;                   // msr index width
  localparam logic [3:0] IdxFix64k = 4'h0;   // fixed_type_64k_low
  localparam logic [3:0] IdxFix16k = 4'h1;   // first of two 16k regs
  localparam logic [3:0] IdxFix4k = 4'h3;    // first of eight 4k regs
  localparam logic [3:0] IdxDefType = 4'hB;  // default_type_register
  localparam logic [3:0] IdxExtCtl = 4'hC;   // extended encoding control
  // field positions
  localparam int TypeW = 3;                  // type code bits 2:0
  localparam int FieldW = 8;                 // byte-wide type field
  localparam int WrMemBit = 3;               // write_to_memory_bit
  localparam int RdMemBit = 4;               // read_to_memory_bit
  localparam int FeBit = 10;                 // fixed_range_enable
  localparam int EnBit = 11;                 // global enable
  localparam int ExtEnBit = 0;               // extended encoding enable
  // address slicing below one megabyte
  localparam int LowMegBits = 20;
  localparam logic [19:0] End64k = 20'h80000;
  localparam logic [19:0] End16k = 20'hC0000;
  localparam int Sel64kLsb = 16;
  localparam int Sel16kLsb = 14;
  localparam int Sel4kLsb = 12;
  localparam int Blk16kBit = 17;
  localparam int Blk4kLsb = 15;
  // reset values
  localparam logic [63:0] FixReset = 64'h0;
  localparam logic [7:0] DefTypeReset = 8'h00;
  // standard type codes
  localparam logic [2:0] TypeUc = 3'h0;
  localparam logic [2:0] TypeWc = 3'h1;
  localparam logic [2:0] TypeWt = 3'h4;
  localparam logic [2:0] TypeWp = 3'h5;
  localparam logic [2:0] TypeWb = 3'h6;
  // decoded permissions of one type
  typedef struct packed {
    logic cacheable;
    logic wcAllowed;
    logic specAllowed;
    logic readAlloc;
    logic writeAlloc;
    logic writeThrough;
    logic hitInvalidate;
    logic allocModified;
    logic undefinedType;
  } attr_t;
endpackage

//--- verilog/type_attr_decoder.sv
// decodes a three-bit memory type into permissions
// assumes a combinational caller that registers the result
`timescale 1ns/100ps
module type_attr_decoder (
  // clock, only for the checks
  input wire logic    sys_clk,
  input wire logic    reset_n,
  // type in, attributes out
  type_attr_if.decoder tif
);
  // one case per standard code
  always_comb begin
    tif.attr = '0;
    unique case (tif.memType)
      range_type_pkg::TypeUc: begin
        tif.attr = '0;
      end
      range_type_pkg::TypeWc: begin
        tif.attr.wcAllowed   = 1'b1;
        tif.attr.specAllowed = 1'b1;
      end
      range_type_pkg::TypeWt: begin
        tif.attr.cacheable    = 1'b1;
        tif.attr.readAlloc    = 1'b1;
        tif.attr.writeThrough = 1'b1;
      end
      range_type_pkg::TypeWp: begin
        tif.attr.cacheable     = 1'b1;
        tif.attr.readAlloc     = 1'b1;
        tif.attr.writeThrough  = 1'b1;
        tif.attr.hitInvalidate = 1'b1;
      end
      range_type_pkg::TypeWb: begin
        tif.attr.cacheable     = 1'b1;
        tif.attr.readAlloc     = 1'b1;
        tif.attr.writeAlloc    = 1'b1;
        tif.attr.allocModified = 1'b1;
      end
      default: begin
        // codes 2, 3, 7: flagged, never cached
        tif.attr.undefinedType = 1'b1;
      end
    endcase
  end

  a_uc_blocks_all: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tif.memType == range_type_pkg::TypeUc |-> tif.attr == '0)
    else $error("uncacheable type grants a permission");
  a_wc_no_cache: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tif.memType == range_type_pkg::TypeWc
      |-> !tif.attr.cacheable && tif.attr.wcAllowed && tif.attr.specAllowed)
    else $error("write-combining permissions wrong");
  a_wb_alloc_mod: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tif.memType == range_type_pkg::TypeWb
      |-> tif.attr.writeAlloc && tif.attr.allocModified && !tif.attr.writeThrough)
    else $error("writeback allocation wrong");
  a_undef_uncached: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tif.attr.undefinedType |-> !tif.attr.cacheable && !tif.attr.wcAllowed)
    else $error("undefined type is cached");
endmodule

//--- verilog/type_attr_if.sv
// carrier between lookup and type decoder
// assumes range_type_pkg is compiled first
`timescale 1ns/100ps
interface type_attr_if;
  logic [2:0]                 memType;  // type code to decode
  range_type_pkg::attr_t      attr;     // decoded permissions
  modport decoder (input memType, output attr);
  modport user    (output memType, input attr);
endinterface
